// ==== design/spic_defs.vh ====
// Constants for the serial register port with interrupt flags and read checksum.
// Included by every design file of the port; holds definitions only.
`ifndef SPIC_DEFS_VH
`define SPIC_DEFS_VH

`define SPIC_ADDR_W 6
`define SPIC_CMD_WRITE_BIT 7
`define SPIC_A_IRQ_EN 6'h0f
`define SPIC_A_FLAGS 6'h10
`define SPIC_A_FLAGS_RC 6'h11
`define SPIC_A_SUM 6'h3e
`define SPIC_FLAG_W 16
`define SPIC_SUM_W 6
`define SPIC_IRQ_EN_RESET 16'h0000
`define SPIC_LEN_FLAGS 5'h10
`define SPIC_LEN_SUM 5'h08
`define SPIC_WORD_BITS 24

`endif

// ==== design/spic_sync.v ====
// Two-stage synchroniser for a group of asynchronous pins.
// Assumes the inputs are levels that change slowly against clk_i.
`timescale 1ns/1ps
`include "spic_defs.vh"

module spic_sync #(
    parameter W = 3
) (
    input wire clk_i,
    input wire reset_i,
    input wire [W-1:0] async_i,
    input wire [W-1:0] reset_value_i,
    output reg [W-1:0] sync_o
);
    reg [W-1:0] meta;

    // Only the second stage is read outside this module
    always @(posedge clk_i) begin
        if (reset_i) begin
            // Reset to reset_value_i; the port gives cs_n its idle high level so no false select fall follows reset
            meta <= reset_value_i;
            sync_o <= reset_value_i;
        end else begin
            meta <= async_i;
            sync_o <= meta;
        end
    end
endmodule // spic_sync

// ==== design/spic_irq.v ====
// Interrupt flags, enable gating and active-low request line.
// Assumes events are one-cycle pulses on clk_i; clear mask comes with clear_i.
`timescale 1ns/1ps
`include "spic_defs.vh"

module spic_irq #(
    parameter W = `SPIC_FLAG_W
) (
    input wire clk_i,
    input wire reset_i,
    input wire [W-1:0] events_i,
    input wire [W-1:0] enable_i,
    input wire clear_i,
    input wire [W-1:0] clear_mask_i,
    input wire hold_i,
    output reg [W-1:0] flags_o,
    output reg irq_n_o
);
    wire [W-1:0] next_flags;

    // Set wins over clear, so an event during a clearing read stays pending
    assign next_flags = (flags_o & ~(clear_i ? clear_mask_i : {W{1'b0}})) | events_i;

    always @(posedge clk_i) begin
        if (reset_i) begin
            flags_o <= {W{1'b0}};
            irq_n_o <= 1'b1;
        end else begin
            flags_o <= next_flags;
            irq_n_o <= ~((|(next_flags & enable_i)) & ~hold_i);
        end
    end
endmodule // spic_irq

// ==== design/spic_port.v ====
// Serial register port: command decode, byte writes, snapshot reads, checksum, interrupts.
// Assumes sclk/din/cs_n pins are asynchronous to clk_i and sclk is far slower than clk_i;
// read data of other registers comes back combinationally from reg_addr_o; ext_len_i is taken while reg_addr_o still holds the previous address.
`timescale 1ns/1ps
`include "spic_defs.vh"

module spic_port #(
    parameter FLAG_W = `SPIC_FLAG_W
) (
    input wire clk_i,
    input wire reset_i,
    input wire sclk_i,
    input wire din_i,
    input wire cs_n_i,
    output reg dout_o,
    output reg dout_oe_n_o,
    output wire irq_o,
    output wire irq_oe_n_o,
    input wire [FLAG_W-1:0] events_i,
    output reg [5:0] reg_addr_o,
    input wire [1:0] ext_len_i,
    input wire [23:0] ext_rdata_i,
    output reg wr_stb_o,
    output reg [1:0] wr_sel_o,
    output reg [7:0] wr_data_o,
    output reg [15:0] irq_en_o
);
    localparam ST_CMD = 2'd0;
    localparam ST_LOAD = 2'd1;
    localparam ST_WR = 2'd2;
    localparam ST_RD = 2'd3;

    wire [2:0] pins_s;
    wire sclk_s;
    wire din_s;
    wire cs_n_s;
    reg sclk_d;
    reg cs_n_d;
    wire sclk_rise;
    wire sclk_fall;
    wire cs_fall;

    reg [1:0] state;
    reg [7:0] sh_in;
    reg [4:0] cnt;
    reg [4:0] nbits;
    reg [23:0] sh_out;
    reg [5:0] sum;
    reg hold;
    reg clr;
    reg [FLAG_W-1:0] clr_mask;
    reg [23:0] rd_word;
    reg [4:0] len_bits;
    wire [FLAG_W-1:0] flags;
    wire irq_n;
    wire [7:0] next_sh_in;
    wire [4:0] next_cnt;

    spic_sync #(
        .W(3)
    ) u_sync (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .async_i({sclk_i, din_i, cs_n_i}),
        .reset_value_i(3'h1),
        .sync_o(pins_s)
    );

    assign sclk_s = pins_s[2];
    assign din_s = pins_s[1];
    // Chip select resets high in the synchroniser, so reset gives no false select fall
    assign cs_n_s = pins_s[0];
    assign sclk_rise = sclk_s & ~sclk_d & ~cs_n_s;
    assign sclk_fall = ~sclk_s & sclk_d & ~cs_n_s;
    assign cs_fall = cs_n_d & ~cs_n_s;
    assign next_sh_in = {sh_in[6:0], din_s};
    assign next_cnt = cnt + 5'h01;

    spic_irq #(
        .W(FLAG_W)
    ) u_irq (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .events_i(events_i),
        .enable_i(irq_en_o),
        .clear_i(clr),
        .clear_mask_i(clr_mask),
        .hold_i(hold),
        .flags_o(flags),
        .irq_n_o(irq_n)
    );

    // Open drain: value always low, enable low while pulling the line down
    assign irq_o = 1'b0;
    assign irq_oe_n_o = irq_n;

    // Register length in bits for the address being decoded
    always @* begin
        case (next_sh_in[5:0])
            `SPIC_A_IRQ_EN, `SPIC_A_FLAGS, `SPIC_A_FLAGS_RC: len_bits = `SPIC_LEN_FLAGS;
            `SPIC_A_SUM: len_bits = `SPIC_LEN_SUM;
            default: len_bits = (ext_len_i == 2'd0) ? 5'h08 : {ext_len_i, 3'b000};
        endcase
    end

    always @* begin
        case (reg_addr_o)
            `SPIC_A_IRQ_EN: rd_word = {8'h00, irq_en_o};
            `SPIC_A_FLAGS, `SPIC_A_FLAGS_RC: rd_word = {8'h00, flags};
            `SPIC_A_SUM: rd_word = {18'h00000, sum};
            default: rd_word = ext_rdata_i;
        endcase
    end

    always @(posedge clk_i) begin
        if (reset_i) begin
            sclk_d <= 1'b0;
            cs_n_d <= 1'b1;
        end else begin
            sclk_d <= sclk_s;
            cs_n_d <= cs_n_s;
        end
    end

    always @(posedge clk_i) begin
        if (reset_i) begin
            state <= ST_CMD;
            sh_in <= 8'h00;
            cnt <= 5'h00;
            nbits <= 5'h00;
            sh_out <= 24'h000000;
            sum <= 6'h00;
            hold <= 1'b0;
            clr <= 1'b0;
            clr_mask <= {FLAG_W{1'b0}};
            dout_o <= 1'b0;
            dout_oe_n_o <= 1'b1;
            reg_addr_o <= 6'h00;
            wr_stb_o <= 1'b0;
            wr_sel_o <= 2'd0;
            wr_data_o <= 8'h00;
            irq_en_o <= `SPIC_IRQ_EN_RESET;
        end else begin
            wr_stb_o <= 1'b0;
            clr <= 1'b0;
            if (cs_n_s) begin
                // Abort: partial write byte is dropped, output floats at once
                state <= ST_CMD;
                cnt <= 5'h00;
                dout_oe_n_o <= 1'b1;
                hold <= 1'b0;
            end else if (cs_fall) begin
                state <= ST_CMD;
                cnt <= 5'h00;
                dout_oe_n_o <= 1'b1;
            end else begin
                case (state)
                    ST_CMD: begin
                        if (sclk_fall) begin
                            sh_in <= next_sh_in;
                            cnt <= next_cnt;
                            if (cnt == 5'd7) begin
                                cnt <= 5'h00;
                                reg_addr_o <= next_sh_in[5:0];
                                nbits <= len_bits;
                                if (next_sh_in[`SPIC_CMD_WRITE_BIT]) begin
                                    state <= ST_WR;
                                end else begin
                                    state <= ST_LOAD;
                                    // Line released from the command's last falling edge
                                    if (next_sh_in[5:0] == `SPIC_A_FLAGS_RC) begin
                                        hold <= 1'b1;
                                    end
                                end
                            end
                        end
                    end
                    ST_LOAD: begin
                        // Whole word frozen now; later updates cannot tear it
                        sh_out <= rd_word << (5'd24 - nbits);
                        sum <= 6'h00;
                        state <= ST_RD;
                        if (reg_addr_o == `SPIC_A_FLAGS_RC) begin
                            clr <= 1'b1;
                            clr_mask <= flags;
                        end
                    end
                    ST_WR: begin
                        if (sclk_fall) begin
                            sh_in <= next_sh_in;
                            cnt <= next_cnt;
                            if (cnt[2:0] == 3'd7) begin
                                wr_stb_o <= 1'b1;
                                wr_data_o <= next_sh_in;
                                wr_sel_o <= nbits[4:3] - next_cnt[4:3];
                                if (reg_addr_o == `SPIC_A_IRQ_EN) begin
                                    if (nbits[4:3] - next_cnt[4:3] == 2'd1) begin
                                        irq_en_o[15:8] <= next_sh_in;
                                    end else begin
                                        irq_en_o[7:0] <= next_sh_in;
                                    end
                                end
                                if (next_cnt == nbits) begin
                                    state <= ST_CMD;
                                    cnt <= 5'h00;
                                end
                            end
                        end
                    end
                    ST_RD: begin
                        if (sclk_rise && cnt != nbits) begin
                            dout_o <= sh_out[23];
                            dout_oe_n_o <= 1'b0;
                            sh_out <= {sh_out[22:0], 1'b0};
                            sum <= sum + {5'h00, sh_out[23]};
                            cnt <= next_cnt;
                        end else if (sclk_fall && cnt == nbits) begin
                            dout_oe_n_o <= 1'b1;
                            state <= ST_CMD;
                            cnt <= 5'h00;
                            hold <= 1'b0;
                        end
                    end
                    default: state <= ST_CMD;
                endcase
            end
        end
    end
endmodule // spic_port

// ==== bench/spic_port_asserts.sv ====
// Pin-level checks on the serial register port.
// Assumes binding to spic_port; raw sclk edges reach the logic a few clocks late.
`timescale 1ns/1ps
module spic_port_asserts (
    input wire clk_i,
    input wire reset_i,
    input wire sclk_i,
    input wire cs_n_i,
    input wire dout_o,
    input wire dout_oe_n_o,
    input wire irq_o,
    input wire irq_oe_n_o,
    input wire wr_stb_o,
    input wire [15:0] irq_en_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    reg sclk_q;
    reg [3:0] rise_age;
    reg [3:0] fall_age;
    // Ages saturate so a long idle never wraps back into the window
    always @(posedge clk_i) begin
        sclk_q <= sclk_i;
        if (reset_i || (sclk_i && !sclk_q)) rise_age <= reset_i ? 4'hf : 4'h0;
        else if (rise_age != 4'hf) rise_age <= rise_age + 4'h1;
        if (reset_i || (!sclk_i && sclk_q)) fall_age <= reset_i ? 4'hf : 4'h0;
        else if (fall_age != 4'hf) fall_age <= fall_age + 4'h1;
    end
    sequence cs_rise_s;
        $rose(cs_n_i);
    endsequence
    chk_reset_idle: assert property (disable iff (1'b0) reset_i |=>
        dout_oe_n_o && irq_oe_n_o && irq_en_o == 16'h0000) else $error("not idle after reset");
    chk_abort_float: assert property (cs_rise_s |-> ##[1:6] dout_oe_n_o)
        else $error("no float after select rise");
    chk_idle_float: assert property (cs_n_i [*8] |-> dout_oe_n_o)
        else $error("driving while deselected");
    chk_irq_drain: assert property (irq_o == 1'b0)
        else $error("interrupt pin value not low");
    chk_irq_masked: assert property (!irq_oe_n_o |-> (|irq_en_o) || (|$past(irq_en_o)))
        else $error("interrupt with no enable");
    chk_dout_rise: assert property (!dout_oe_n_o && !$past(dout_oe_n_o) && $changed(dout_o)
        |-> rise_age < 4'h8) else $error("data out moved without sclk rise");
    chk_oe_on_rise: assert property ($fell(dout_oe_n_o) |-> rise_age < 4'h8)
        else $error("drive started without sclk rise");
    chk_wr_after_fall: assert property (wr_stb_o |-> fall_age < 4'h8 ##1 !wr_stb_o)
        else $error("write strobe not tied to sclk fall");
endmodule // spic_port_asserts

bind spic_port spic_port_asserts spic_port_asserts_i (.clk_i(clk_i), .reset_i(reset_i),
    .sclk_i(sclk_i), .cs_n_i(cs_n_i), .dout_o(dout_o), .dout_oe_n_o(dout_oe_n_o),
    .irq_o(irq_o), .irq_oe_n_o(irq_oe_n_o), .wr_stb_o(wr_stb_o), .irq_en_o(irq_en_o));

// ==== bench/spic_host.sv ====
// Host master model for the serial port; sclk idles high and stands still between frames.
// Assumes clk_i is the device clock; every pin change lands on its falling edge.
`timescale 1ns/1ps
module spic_host (
    input wire clk_i,
    input wire dout_i,
    input wire dout_oe_n_i,
    output logic sclk_o,
    output logic din_o,
    output logic cs_n_o
);
    initial begin
        sclk_o = 1'b1;
        din_o = 1'b0;
        cs_n_o = 1'b1;
    end
    task automatic hw(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // A floating data line reads back as unknown, so a compare catches it
    task automatic xfer(input [7:0] cmd, input int nb, input [23:0] wd, input int stop,
            output logic [23:0] rd);
        int i;
        logic [31:0] sh;
        sh = {cmd, 24'h000000} | ({8'h00, wd} << (24 - nb));
        rd = 24'h000000;
        cs_n_o = 1'b0;
        hw(4);
        for (i = 0; i < 8 + nb && i != stop; i++) begin
            din_o = sh[31 - i];
            hw(4);
            if (i >= 8) rd = {rd[22:0], dout_oe_n_i ? 1'bx : dout_i};
            sclk_o = 1'b0;
            hw(4);
            sclk_o = 1'b1;
        end
        hw(4);
        cs_n_o = 1'b1;
        din_o = ~din_o;
        hw(40);
    endtask
endmodule // spic_host

// ==== bench/testbench.sv ====
// Self-checking bench: writes, reads, aborts, interrupt flags and the read checksum.
// Assumes spic_host drives every serial pin of the port.
`timescale 1ns/1ps
`include "spic_defs.vh"
module testbench;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [15:0] ev = 16'h0000;
    logic [23:0] xd = 24'hc3a5f0;
    wire sclk, din, cs_n, dout, oe_n, irq_n;
    wire [15:0] en;
    logic [23:0] rd;
    int fails = 0;
    int tests_run = 0;
    int cycles = 0;
    spic_port spic_port_i (.clk_i(clk_i), .reset_i(reset_i), .sclk_i(sclk), .din_i(din),
        .cs_n_i(cs_n), .dout_o(dout), .dout_oe_n_o(oe_n), .irq_o(), .irq_oe_n_o(irq_n),
        .events_i(ev), .reg_addr_o(), .ext_len_i(2'h3), .ext_rdata_i(xd), .wr_stb_o(),
        .wr_sel_o(), .wr_data_o(), .irq_en_o(en));
    spic_host spic_host_i (.clk_i(clk_i), .dout_i(dout), .dout_oe_n_i(oe_n), .sclk_o(sclk),
        .din_o(din), .cs_n_o(cs_n));
    initial begin
        forever #12.5 clk_i = ~clk_i;
    end
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdr(input [5:0] a, input int nb, input logic [23:0] exp);
        spic_host_i.xfer({2'b00, a}, nb, 24'h000000, 99, rd);
        chk(rd, exp);
    endtask
    task automatic pulse(input [15:0] e);
        @(negedge clk_i);
        ev = e;
        @(negedge clk_i);
        ev = 16'h0000;
        repeat (4) @(negedge clk_i);
    endtask
    task automatic wrap_up;
        $display("tests_run %0d fails %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            wrap_up();
        end
    end
    initial begin
        repeat (5) @(negedge clk_i);
        reset_i = 1'b0;
        chk({oe_n, irq_n, en}, {2'b11, 16'h0000});
        repeat (4) @(negedge clk_i);
        $display("test reset done");
        spic_host_i.xfer(8'h8f, 16, 24'h000001, 99, rd);
        chk(en, 24'h000001);
        rdr(`SPIC_A_IRQ_EN, 16, 24'h000001);
        $display("test write_read done");
        spic_host_i.xfer(8'h8f, 16, 24'h00ffff, 12, rd);
        chk(en, 24'h000001);
        rdr(`SPIC_A_IRQ_EN, 16, 24'h000001);
        $display("test abort done");
        pulse(16'h0010);
        chk(irq_n, 1'b1);
        pulse(16'h0001);
        chk(irq_n, 1'b0);
        rdr(`SPIC_A_FLAGS, 16, 24'h000011);
        fork
            rdr(`SPIC_A_FLAGS_RC, 16, 24'h000011);
            begin
                repeat (130) @(negedge clk_i);
                chk(irq_n, 1'b1);
                pulse(16'h0001);
                chk(irq_n, 1'b1);
            end
        join
        chk(irq_n, 1'b0);
        rdr(`SPIC_A_FLAGS_RC, 16, 24'h000001);
        chk(irq_n, 1'b1);
        rdr(`SPIC_A_FLAGS, 16, 24'h000000);
        $display("test interrupts done");
        fork
            rdr(6'h01, 24, 24'hc3a5f0);
            begin
                repeat (150) @(negedge clk_i);
                xd = 24'h000000;
            end
        join
        rdr(`SPIC_A_SUM, 8, 24'h00000c);
        rdr(`SPIC_A_SUM, 8, 24'h000002);
        $display("test snapshot_sum done");
        wrap_up();
    end
endmodule // testbench
